//--- mev_pkg.sv
// constants for the modem event, alert and v.23 turnaround block
package mev_pkg;
   // register addresses on the plain register port
   localparam logic [7:0] ADDR_MODULATION_FORMAT = 8'h07;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h09;
   localparam logic [7:0] ADDR_MISC_CFG = 8'h0C;
   localparam logic [7:0] ADDR_LOOP_DIFF = 8'h11;
   localparam logic [7:0] ADDR_LOOP_REF = 8'h12;
   localparam logic [7:0] ADDR_SERIAL_FORMAT = 8'h15;
   localparam logic [7:0] ADDR_OVERCURRENT_DELAY = 8'h32;
   localparam logic [7:0] ADDR_RESULT_CODE_CFG = 8'h62;
   localparam logic [7:0] ADDR_PIN_FUNCTION = 8'hE2;

   // status bit positions (mask bits share them, except carrier loss and reversal, which has no mask bit)
   localparam int ST_CARRIER_LOSS = 0;
   localparam int ST_OVERCURRENT = 1;
   localparam int ST_RING = 2;
   localparam int ST_INTRUSION = 3;
   localparam int ST_NO_LOOP = 4;
   localparam int ST_WAKE = 5;
   localparam int ST_REVERSAL = 7;
   localparam int MK_CARRIER_LOSS = 7;

   // field positions
   localparam int MF_SLOW_TX = 5;
   localparam int MF_FAST_TX = 4;
   localparam int MF_RATE_1200 = 2;
   localparam int RC_LOOP_RESULT = 1;
   localparam int MC_CARRIER_PIN = 7;
   localparam int MC_NINTH_FUNCTION = 3;
   localparam int SF_NINTH_ENABLE = 0;
   localparam int PF_ALERT_HI = 7;
   localparam int PF_ALERT_LO = 6;
   localparam int PF_GP2_HI = 3;
   localparam int PF_GP2_LO = 2;
   localparam logic [1:0] PF_ALERT_SEL = 2'h3;
   localparam logic [1:0] PF_GP2_CARRIER = 2'h1;

   // reset values
   localparam logic [7:0] RST_MODULATION_FORMAT = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_MISC_CFG = 8'h00;
   localparam logic [4:0] RST_LOOP_DIFF = 5'h00;
   localparam logic [7:0] RST_LOOP_REF = 8'h00;
   localparam logic [7:0] RST_SERIAL_FORMAT = 8'h00;
   localparam logic [7:0] RST_OVERCURRENT_DELAY = 8'h14;
   localparam logic [7:0] RST_RESULT_CODE_CFG = 8'h00;
   localparam logic [7:0] RST_PIN_FUNCTION = 8'hC0;

   // result characters
   localparam logic [7:0] CH_LOOP_LOST = 8'h49;
   localparam logic [7:0] CH_LOOP_BACK = 8'h4C;
   localparam logic [7:0] CH_FAST_TX = 8'h63;
   localparam logic [7:0] CH_SLOW_TX = 8'h76;
   localparam logic [7:0] CH_NO_CARRIER = 8'h4E;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int T_MASTER_WIN_MS = 440;
   localparam int T_SLAVE_FWD_WIN_MS = 400;
   localparam int T_SLAVE_BACK_WIN_MS = 440;
   localparam int T_TONE_MIN_MS = 40;
   localparam int T_DROP_MIN_MS = 20;

   typedef enum logic [1:0] {
      TA_IDLE,
      TA_MASTER,
      TA_SLAVE_FWD,
      TA_SLAVE_BACK
   } mev_ta_state_t;
endpackage : mev_pkg

//--- mev_modem_event.sv
// modem event flags, alert line, ninth-bit alert and v.23 turnaround sequencer
// Function
// - alert line driven for each event source whose mask bit is set
// - host clear command clears status bits and releases the alert line high
// - status bits are sticky until the clear command
// - loop-loss monitoring off at reset, on via mask bit 4, sets status bit 4
// - with result bit 1 and mask bit 4, report I on loop loss and L on return
// - carrier loss in data mode alerts when pin is alert and mask bit 7 set
// - second pin function 01 plus carrier pin enable gives carrier detect output
// - overcurrent checking starts a programmable delay after off-hook, default 20 ms
// - overcurrent sets status bit 1 and alerts if pin is alert and mask bit 1
// - v.23 selected when format is xx10xx00 or xx01xx00
// - bit 5 sends at 75 bps receives fast; bit 4 the reverse
// - fast channel runs 1200 bps with rate bit 2 set, else 600
// - on v.23 connect report c when sending fast, v when sending slow
// - master turnaround goes to 1300 Hz, c if over 40 ms tone in 440 ms else N
// - slave reverses after 20 ms drop; over 40 ms of 1300 Hz in 400 ms gives bit 7 and v
// - else reverse back, over 40 ms of 390 Hz gives bit 7 and c, else hang up, bit 7, N
// - successful master or forward slave turnaround rewrites direction bits 4 and 5; reverse back keeps them
// - ninth bit enable with function bit 0 carries the alert condition
// - intrusion only after two successive samples below reference by over the difference
`timescale 1ns/1ps
`default_nettype none
module mev_modem_event #(
   parameter int MS_CYCLES = mev_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // host commands, decoded upstream
   input wire logic irq_clear_command,
   input wire logic turnaround_command,
   // line and data pump status
   input wire logic off_hook,
   input wire logic data_mode,
   input wire logic link_connected,
   input wire logic carrier_present,
   input wire logic tone_390_present,
   input wire logic tone_1300_present,
   input wire logic loop_current_low,
   input wire logic overcurrent_detect,
   input wire logic ring_detect,
   input wire logic wake_event,
   input wire logic loop_sample_valid,
   input wire logic [7:0] loop_current_sample,
   // pins and serial path
   output logic alert_n,
   output logic carrier_detect_n,
   output logic ninth_bit_alert,
   // v.23 data pump control
   output logic v23_active,
   output logic tx_fast_channel,
   output logic fast_rate_1200,
   output logic tx_carrier_1300,
   output logic hang_up,
   // result characters to the serial path
   output logic [7:0] result_char,
   output logic result_valid
);
   import mev_pkg::*;

   typedef struct packed {
      logic [7:0] mod_fmt;
      logic [7:0] mask;
      logic [7:0] status;
      logic [7:0] misc;
      logic [4:0] loop_diff;
      logic [7:0] loop_ref;
      logic [7:0] serial;
      logic [7:0] ocd_delay;
      logic [7:0] result_cfg;
      logic [7:0] pin_fn;
      logic [7:0] rdata;
      logic [15:0] ms_div;
      logic ms_tick;
      logic [7:0] offhook_ms;
      logic carrier_q;
      logic loop_low_q;
      logic below_prev;
      mev_ta_state_t ta;
      logic [8:0] win_ms;
      logic [5:0] tone_ms;
      logic [4:0] drop_ms;
      logic tx_hi;
      logic hangup;
      logic [7:0] rchar;
      logic rvalid;
      logic alert_n;
      logic ninth;
      logic cd_n;
      logic v23;
      logic fast;
      logic rate;
   } mev_state_t;

   mev_state_t q;
   mev_state_t next_q;

   function automatic logic v23_sel(input logic [7:0] f);
      v23_sel = (f[5:4] == 2'h2 || f[5:4] == 2'h1) && f[1:0] == 2'h0;
   endfunction : v23_sel

   // reversal alerts whatever the mask
   function automatic logic alert_any(input logic [7:0] st, input logic [7:0] mk);
      logic [7:0] en;
      en = mk;
      en[ST_CARRIER_LOSS] = mk[MK_CARRIER_LOSS];
      en[ST_REVERSAL] = 1'b1;
      en[6] = 1'b0;
      alert_any = |(st & en);
   endfunction : alert_any

   function automatic logic [7:0] read_mux(input mev_state_t s, input logic [7:0] a);
      unique case (a)
         ADDR_MODULATION_FORMAT: read_mux = s.mod_fmt;
         ADDR_IRQ_MASK: read_mux = s.mask;
         ADDR_IRQ_STATUS: read_mux = s.status;
         ADDR_MISC_CFG: read_mux = s.misc;
         ADDR_LOOP_DIFF: read_mux = {3'h0, s.loop_diff};
         ADDR_LOOP_REF: read_mux = s.loop_ref;
         ADDR_SERIAL_FORMAT: read_mux = s.serial;
         ADDR_OVERCURRENT_DELAY: read_mux = s.ocd_delay;
         ADDR_RESULT_CODE_CFG: read_mux = s.result_cfg;
         ADDR_PIN_FUNCTION: read_mux = s.pin_fn;
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   logic v23;
   logic is_alert_pin;
   logic carrier_lost;
   logic below;
   logic ta_success;
   logic ta_window_over;
   logic [7:0] set_bits;

   always_comb begin
      next_q = q;
      next_q.ms_tick = 1'b0;
      next_q.hangup = 1'b0;
      next_q.rvalid = 1'b0;
      set_bits = 8'h00;
      v23 = v23_sel(q.mod_fmt);
      is_alert_pin = q.pin_fn[PF_ALERT_HI:PF_ALERT_LO] == PF_ALERT_SEL;
      carrier_lost = q.carrier_q && !carrier_present && data_mode;
      below = (q.loop_ref > loop_current_sample)
         && ((q.loop_ref - loop_current_sample) > {3'h0, q.loop_diff});
      ta_success = 1'b0;
      ta_window_over = 1'b0;

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_MODULATION_FORMAT: next_q.mod_fmt = reg_wdata;
            ADDR_IRQ_MASK: next_q.mask = reg_wdata;
            ADDR_MISC_CFG: next_q.misc = reg_wdata;
            ADDR_LOOP_DIFF: next_q.loop_diff = reg_wdata[4:0];
            ADDR_LOOP_REF: next_q.loop_ref = reg_wdata;
            ADDR_SERIAL_FORMAT: next_q.serial = reg_wdata;
            ADDR_OVERCURRENT_DELAY: next_q.ocd_delay = reg_wdata;
            ADDR_RESULT_CODE_CFG: next_q.result_cfg = reg_wdata;
            ADDR_PIN_FUNCTION: next_q.pin_fn = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         next_q.rdata = read_mux(q, reg_addr);
      end

      // millisecond time base
      if (q.ms_div == 16'(MS_CYCLES - 1)) begin
         next_q.ms_div = 16'h0000;
         next_q.ms_tick = 1'b1;
      end else begin
         next_q.ms_div = q.ms_div + 16'h0001;
      end

      // time since going off-hook, saturating
      if (!off_hook) begin
         next_q.offhook_ms = 8'h00;
      end else if (q.ms_tick && q.offhook_ms != 8'hFF) begin
         next_q.offhook_ms = q.offhook_ms + 8'h01;
      end

      next_q.carrier_q = carrier_present;
      next_q.loop_low_q = loop_current_low;

      // event sources
      if (carrier_lost) begin
         set_bits[ST_CARRIER_LOSS] = 1'b1;
      end
      if (off_hook && q.offhook_ms >= q.ocd_delay && overcurrent_detect) begin
         set_bits[ST_OVERCURRENT] = 1'b1;
      end
      if (ring_detect) begin
         set_bits[ST_RING] = 1'b1;
      end
      if (wake_event) begin
         set_bits[ST_WAKE] = 1'b1;
      end
      if (q.mask[ST_NO_LOOP] && off_hook && loop_current_low) begin
         set_bits[ST_NO_LOOP] = 1'b1;
      end
      if (!off_hook) begin
         next_q.below_prev = 1'b0;
      end else if (loop_sample_valid) begin
         next_q.below_prev = below;
         if (below && q.below_prev) begin
            set_bits[ST_INTRUSION] = 1'b1;
         end
      end

      // loop-current result characters
      if (q.result_cfg[RC_LOOP_RESULT] && off_hook && q.mask[ST_NO_LOOP]) begin
         if (loop_current_low && !q.loop_low_q) begin
            next_q.rchar = CH_LOOP_LOST;
            next_q.rvalid = 1'b1;
         end else if (!loop_current_low && q.loop_low_q) begin
            next_q.rchar = CH_LOOP_BACK;
            next_q.rvalid = 1'b1;
         end
      end
      if (link_connected && v23) begin
         next_q.rchar = q.mod_fmt[MF_FAST_TX] ? CH_FAST_TX : CH_SLOW_TX;
         next_q.rvalid = 1'b1;
      end

      // carrier drop timer for the slave side
      if (carrier_present) begin
         next_q.drop_ms = 5'h00;
      end else if (q.ms_tick && q.drop_ms != 5'h1F) begin
         next_q.drop_ms = q.drop_ms + 5'h01;
      end

      // turnaround window counters
      if (q.ta != TA_IDLE && q.ms_tick) begin
         next_q.win_ms = q.win_ms + 9'h001;
         if (q.tx_hi ? tone_390_present : tone_1300_present) begin
            if (q.tone_ms != 6'h3F) begin
               next_q.tone_ms = q.tone_ms + 6'h01;
            end
         end
      end
      ta_success = q.tone_ms > 6'(T_TONE_MIN_MS);

      unique case (q.ta)
         TA_IDLE: begin
            next_q.tx_hi = q.mod_fmt[MF_FAST_TX];
            next_q.win_ms = 9'h000;
            next_q.tone_ms = 6'h00;
            // requests from a fast sender are ignored
            if (turnaround_command && v23 && q.mod_fmt[MF_SLOW_TX]) begin
               next_q.ta = TA_MASTER;
               next_q.tx_hi = 1'b1;
            end else if (v23 && data_mode && q.mod_fmt[MF_FAST_TX]
                         && q.drop_ms > 5'(T_DROP_MIN_MS)) begin
               next_q.ta = TA_SLAVE_FWD;
               next_q.tx_hi = 1'b0;
            end
         end
         TA_MASTER: begin
            ta_window_over = q.win_ms >= 9'(T_MASTER_WIN_MS);
            if (ta_success) begin
               next_q.ta = TA_IDLE;
               next_q.mod_fmt[MF_FAST_TX] = 1'b1;
               next_q.mod_fmt[MF_SLOW_TX] = 1'b0;
               next_q.rchar = CH_FAST_TX;
               next_q.rvalid = 1'b1;
            end else if (ta_window_over) begin
               next_q.ta = TA_IDLE;
               next_q.hangup = 1'b1;
               next_q.rchar = CH_NO_CARRIER;
               next_q.rvalid = 1'b1;
            end
         end
         TA_SLAVE_FWD: begin
            ta_window_over = q.win_ms >= 9'(T_SLAVE_FWD_WIN_MS);
            if (ta_success) begin
               next_q.ta = TA_IDLE;
               set_bits[ST_REVERSAL] = 1'b1;
               next_q.mod_fmt[MF_FAST_TX] = 1'b0;
               next_q.mod_fmt[MF_SLOW_TX] = 1'b1;
               next_q.rchar = CH_SLOW_TX;
               next_q.rvalid = 1'b1;
            end else if (ta_window_over) begin
               next_q.ta = TA_SLAVE_BACK;
               next_q.tx_hi = 1'b1;
               next_q.win_ms = 9'h000;
               next_q.tone_ms = 6'h00;
            end
         end
         TA_SLAVE_BACK: begin
            ta_window_over = q.win_ms >= 9'(T_SLAVE_BACK_WIN_MS);
            if (ta_success) begin
               // original channels again: direction bits kept
               next_q.ta = TA_IDLE;
               set_bits[ST_REVERSAL] = 1'b1;
               next_q.rchar = CH_FAST_TX;
               next_q.rvalid = 1'b1;
            end else if (ta_window_over) begin
               next_q.ta = TA_IDLE;
               set_bits[ST_REVERSAL] = 1'b1;
               next_q.hangup = 1'b1;
               next_q.rchar = CH_NO_CARRIER;
               next_q.rvalid = 1'b1;
            end
         end
      endcase

      // a hardware set in the clear cycle survives the clear
      if (irq_clear_command) begin
         next_q.status = set_bits;
      end else begin
         next_q.status = q.status | set_bits;
      end

      // outputs, registered from the next state
      next_q.alert_n = !(is_alert_pin && alert_any(next_q.status, next_q.mask));
      next_q.ninth = next_q.serial[SF_NINTH_ENABLE] && !next_q.misc[MC_NINTH_FUNCTION]
         && alert_any(next_q.status, next_q.mask);
      next_q.cd_n = !(next_q.pin_fn[PF_GP2_HI:PF_GP2_LO] == PF_GP2_CARRIER
         && next_q.misc[MC_CARRIER_PIN] && carrier_present);
      // channel controls follow the format, hardware swaps included
      next_q.v23 = v23_sel(next_q.mod_fmt);
      next_q.fast = next_q.mod_fmt[MF_FAST_TX];
      next_q.rate = next_q.mod_fmt[MF_RATE_1200];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.mod_fmt <= RST_MODULATION_FORMAT;
         q.mask <= RST_IRQ_MASK;
         q.misc <= RST_MISC_CFG;
         q.loop_diff <= RST_LOOP_DIFF;
         q.loop_ref <= RST_LOOP_REF;
         q.serial <= RST_SERIAL_FORMAT;
         q.ocd_delay <= RST_OVERCURRENT_DELAY;
         q.result_cfg <= RST_RESULT_CODE_CFG;
         q.pin_fn <= RST_PIN_FUNCTION;
         q.ta <= TA_IDLE;
         q.alert_n <= 1'b1;
         q.cd_n <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata = q.rdata;
   assign alert_n = q.alert_n;
   assign carrier_detect_n = q.cd_n;
   assign ninth_bit_alert = q.ninth;
   assign v23_active = q.v23;
   assign tx_fast_channel = q.fast;
   assign fast_rate_1200 = q.rate;
   assign tx_carrier_1300 = q.tx_hi;
   assign hang_up = q.hangup;
   assign result_char = q.rchar;
   assign result_valid = q.rvalid;
endmodule : mev_modem_event
`default_nettype wire

//--- mev_host_model.sv
// host model: answers alerts with a clear and asks for v.23 turnarounds
`timescale 1ns/1ps
`default_nettype none
module mev_host_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // bench requests
   input wire logic auto_clear,
   input wire logic ta_req,
   // device side
   input wire logic alert_n,
   input wire logic v23_active,
   input wire logic tx_fast_channel,
   output logic irq_clear_command,
   output logic turnaround_command
);
   typedef struct packed {
      logic [2:0] wait_cnt;
      logic clr;
      logic ta;
   } mev_host_t;
   mev_host_t s;
   mev_host_t next_s;
   always_comb begin
      next_s = s;
      next_s.clr = 1'b0;
      next_s.wait_cnt = 3'h0;
      // a real host takes a few cycles to notice the alert
      if (auto_clear && !alert_n && !s.clr) begin
         next_s.wait_cnt = s.wait_cnt + 3'h1;
         next_s.clr = (s.wait_cnt == 3'h3);
      end
      // only a slow transmitter may ask for a turnaround
      next_s.ta = ta_req && v23_active && !tx_fast_channel;
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign irq_clear_command = s.clr;
   assign turnaround_command = s.ta;
endmodule : mev_host_model
`default_nettype wire

//--- mev_modem_event_chk.sv
// port assertions for the modem event block
`timescale 1ns/1ps
`default_nettype none
module mev_modem_event_chk #(
   parameter int MS_CYCLES = mev_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register port and commands
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic irq_clear_command,
   input wire logic turnaround_command,
   // events
   input wire logic carrier_present,
   input wire logic overcurrent_detect,
   input wire logic ring_detect,
   input wire logic wake_event,
   input wire logic loop_current_low,
   input wire logic loop_sample_valid,
   // outputs
   input wire logic alert_n,
   input wire logic carrier_detect_n,
   input wire logic ninth_bit_alert,
   input wire logic v23_active,
   input wire logic fast_rate_1200,
   input wire logic tx_carrier_1300,
   input wire logic hang_up,
   input wire logic [7:0] result_char,
   input wire logic result_valid
);
   import mev_pkg::*;
   typedef struct packed {
      logic [7:0] fmt;
      logic [7:0] misc;
      logic [7:0] ser;
      logic [7:0] pf;
   } mev_shadow_t;
   mev_shadow_t s;
   mev_shadow_t next_s;
   logic cfg_wr;
   // shadow of software writes; hardware direction swaps keep the v.23 pattern
   always_comb begin
      next_s = s;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_MODULATION_FORMAT: next_s.fmt = reg_wdata;
            ADDR_MISC_CFG: next_s.misc = reg_wdata;
            ADDR_SERIAL_FORMAT: next_s.ser = reg_wdata;
            ADDR_PIN_FUNCTION: next_s.pf = reg_wdata;
            default: ;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= {RST_MODULATION_FORMAT, RST_MISC_CFG, RST_SERIAL_FORMAT, RST_PIN_FUNCTION};
      end else begin
         s <= next_s;
      end
   end
   assign cfg_wr = reg_wr && (reg_addr == ADDR_IRQ_MASK || reg_addr == ADDR_PIN_FUNCTION);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   clear_release_a: assert property (irq_clear_command && carrier_present
      && $past(carrier_present) && !(overcurrent_detect || ring_detect || wake_event
      || loop_current_low || loop_sample_valid) |=> alert_n) else $error("alert kept");
   alert_sticky_a: assert property (!alert_n && !irq_clear_command && !cfg_wr
      |=> !alert_n) else $error("alert dropped");
   alert_pin_off_a: assert property (s.pf[7:6] != PF_ALERT_SEL
      && $past(s.pf[7:6]) != PF_ALERT_SEL |-> alert_n) else $error("alert on other pin");
   carrier_pin_a: assert property ($stable(s.pf) && $stable(s.misc)
      |-> carrier_detect_n == !(s.pf[3:2] == PF_GP2_CARRIER && s.misc[MC_CARRIER_PIN]
      && $past(carrier_present))) else $error("carrier pin wrong");
   ninth_bit_a: assert property (s.ser[SF_NINTH_ENABLE] && !s.misc[MC_NINTH_FUNCTION]
      && s.pf[7:6] == PF_ALERT_SEL && $stable(s) |-> ninth_bit_alert == !alert_n)
      else $error("ninth bit differs");
   v23_select_a: assert property ($stable(s.fmt)
      |-> v23_active == (s.fmt[1:0] == 2'h0 && (s.fmt[5] ^ s.fmt[4]))) else $error("v23");
   rate_bit_a: assert property ($stable(s.fmt) |-> fast_rate_1200 == s.fmt[MF_RATE_1200])
      else $error("rate bit");
   result_pulse_a: assert property (result_valid |=> !result_valid)
      else $error("result long");
   hang_report_a: assert property (hang_up
      |-> ##[0:1] (result_valid && result_char == CH_NO_CARRIER)) else $error("no N");
   master_carrier_a: assert property (turnaround_command && v23_active
      && !tx_carrier_1300 && s.fmt[MF_SLOW_TX] |=> ##[0:1] tx_carrier_1300)
      else $error("no 1300 Hz");
endmodule : mev_modem_event_chk
bind mev_modem_event mev_modem_event_chk #(.MS_CYCLES(MS_CYCLES)) u_mev_modem_event_chk (.*);
`default_nettype wire

//--- mev_modem_event_bench.sv
// self-checking bench for the modem event block
`timescale 1ns/1ps
`default_nettype none
module mev_modem_event_bench;
   import mev_pkg::*;
   localparam int MSC = 10;
   bit sys_clk, rst_b, reg_wr, reg_rd;
   bit [7:0] reg_addr, reg_wdata, loop_current_sample;
   bit off_hook, data_mode, link_connected, carrier_present;
   bit tone_390_present, tone_1300_present, loop_current_low;
   bit overcurrent_detect, ring_detect, wake_event;
   bit loop_sample_valid, auto_clear, ta_req;
   logic irq_clear_command, turnaround_command, alert_n, carrier_detect_n, ninth_bit_alert;
   logic v23_active, tx_fast_channel, fast_rate_1200, tx_carrier_1300, hang_up, result_valid;
   logic [7:0] reg_rdata, result_char, last_char = 8'h00;
   logic [31:0] lfsr = 32'hDA55;
   logic [7:0] smp [4] = '{8'h5A, 8'h64, 8'h5A, 8'h5A};
   logic [7:0] cfmt [2] = '{8'h20, 8'h14};
   int src [2] = '{ST_RING, ST_WAKE};
   int failures, tests_run;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (result_valid === 1'b1) last_char <= result_char;
   mev_modem_event #(.MS_CYCLES(MSC)) u_mev_modem_event (.*);
   mev_host_model u_mev_host_model (.*);
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   // reports the connection a good swap leads to; a plain connect is a swap undone
   function automatic logic [7:0] ta_char(input logic ok, input logic [7:0] f);
      return ok ? (f[MF_SLOW_TX] ? CH_FAST_TX : CH_SLOW_TX) : CH_NO_CARRIER;
   endfunction : ta_char
   function automatic logic [7:0] swap(input logic [7:0] f);
      return {f[7:6], f[4], f[5], f[3:0]};
   endfunction : swap
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rchk
   task automatic hclr();
      auto_clear <= 1'b1;
      cyc(8);
      auto_clear <= 1'b0;
   endtask : hclr
   task automatic stop_test();
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (40000) @(posedge sys_clk);
      failures++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      rchk(ADDR_IRQ_MASK, RST_IRQ_MASK);
      rchk(ADDR_OVERCURRENT_DELAY, RST_OVERCURRENT_DELAY);
      rchk(ADDR_PIN_FUNCTION, RST_PIN_FUNCTION);
      wr(ADDR_IRQ_STATUS, 8'hFF);
      rchk(ADDR_IRQ_STATUS, 8'h00);
      rchk(8'h5A, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(ADDR_MODULATION_FORMAT, lfsr[7:0]);
         wr(ADDR_IRQ_MASK, lfsr[15:8]);
         rchk(ADDR_IRQ_MASK, lfsr[15:8]);
         chk(tx_fast_channel, lfsr[MF_FAST_TX]);
      end
      wr(ADDR_MODULATION_FORMAT, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h02);
      @(posedge sys_clk);
      off_hook <= 1'b1;
      overcurrent_detect <= 1'b1;
      cyc(15 * MSC);
      chk(alert_n, 1'b1);
      cyc(7 * MSC);
      chk(alert_n, 1'b0);
      @(posedge sys_clk);
      overcurrent_detect <= 1'b0;
      cyc(5);
      rchk(ADDR_IRQ_STATUS, 8'h02);
      hclr();
      chk(alert_n, 1'b1);
      foreach (src[k]) begin
         wr(ADDR_IRQ_MASK, 8'h01 << src[k]);
         @(posedge sys_clk);
         ring_detect <= (k == 0);
         wake_event <= (k == 1);
         @(posedge sys_clk);
         ring_detect <= 1'b0;
         wake_event <= 1'b0;
         cyc(2);
         chk(alert_n, 1'b0);
         rchk(ADDR_IRQ_STATUS, 8'h01 << src[k]);
         hclr();
         rchk(ADDR_IRQ_STATUS, 8'h00);
      end
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_RESULT_CODE_CFG, 8'h02);
      for (int m = 0; m < 2; m++) begin
         last_char = 8'h00;
         if (m == 1) wr(ADDR_IRQ_MASK, 8'h10);
         @(posedge sys_clk);
         loop_current_low <= 1'b1;
         cyc(5);
         chk(last_char, m ? CH_LOOP_LOST : 8'h00);
         rchk(ADDR_IRQ_STATUS, m ? 8'h10 : 8'h00);
         @(posedge sys_clk);
         loop_current_low <= 1'b0;
         cyc(5);
         chk(last_char, m ? CH_LOOP_BACK : 8'h00);
         chk(alert_n, !m);
      end
      hclr();
      wr(ADDR_LOOP_REF, 8'h64);
      wr(ADDR_LOOP_DIFF, 8'h05);
      wr(ADDR_SERIAL_FORMAT, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h08);
      foreach (smp[i]) begin
         @(posedge sys_clk);
         loop_current_sample <= smp[i];
         loop_sample_valid <= 1'b1;
         @(posedge sys_clk);
         loop_sample_valid <= 1'b0;
         cyc(3);
         chk(alert_n, i < 3);
         chk(ninth_bit_alert, i == 3);
      end
      hclr();
      wr(ADDR_IRQ_MASK, 8'h80);
      wr(ADDR_MISC_CFG, 8'h80);
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_PIN_FUNCTION, p ? 8'h04 : 8'hC4);
         @(posedge sys_clk);
         data_mode <= 1'b1;
         carrier_present <= 1'b1;
         cyc(3);
         chk(carrier_detect_n, 1'b0);
         @(posedge sys_clk);
         carrier_present <= 1'b0;
         cyc(3);
         chk(alert_n, p[0]);
         rchk(ADDR_IRQ_STATUS, 8'h01);
         hclr();
      end
      // flag kept while the pin was elsewhere
      wr(ADDR_PIN_FUNCTION, 8'hC0);
      cyc(2);
      chk(alert_n, 1'b0);
      hclr();
      wr(ADDR_IRQ_MASK, 8'h00);
      @(posedge sys_clk);
      carrier_present <= 1'b1;
      foreach (cfmt[j]) begin
         wr(ADDR_MODULATION_FORMAT, cfmt[j]);
         @(posedge sys_clk);
         link_connected <= 1'b1;
         @(posedge sys_clk);
         link_connected <= 1'b0;
         cyc(3);
         chk(last_char, ta_char(1'b1, swap(cfmt[j])));
      end
      for (int t = 1; t >= 0; t--) begin
         wr(ADDR_MODULATION_FORMAT, 8'h24);
         last_char = 8'h00;
         @(posedge sys_clk);
         ta_req <= 1'b1;
         @(posedge sys_clk);
         ta_req <= 1'b0;
         tone_390_present <= t[0];
         cyc(3);
         chk(tx_carrier_1300, 1'b1);
         cyc(t ? 50 * MSC : 450 * MSC);
         chk(last_char, ta_char(t[0], 8'h24));
         rchk(ADDR_MODULATION_FORMAT, t ? swap(8'h24) : 8'h24);
         @(posedge sys_clk);
         tone_390_present <= 1'b0;
      end
      for (int t = 1; t >= 0; t--) begin
         wr(ADDR_MODULATION_FORMAT, 8'h14);
         last_char = 8'h00;
         @(posedge sys_clk);
         carrier_present <= 1'b0;
         tone_1300_present <= t[0];
         cyc(30 * MSC);
         chk(tx_carrier_1300, 1'b0);
         cyc(t ? 60 * MSC : 860 * MSC);
         chk(last_char, ta_char(t[0], 8'h14));
         chk(alert_n, 1'b0);
         rchk(ADDR_IRQ_STATUS, 8'h81);
         rchk(ADDR_MODULATION_FORMAT, t ? swap(8'h14) : 8'h14);
         @(posedge sys_clk);
         tone_1300_present <= 1'b0;
         carrier_present <= 1'b1;
         hclr();
      end
      stop_test();
   end
endmodule : mev_modem_event_bench
`default_nettype wire
